// file: shared/debug_tap_map.svh
// register codes, capture patterns and field widths of the debug tap
`ifndef DEBUG_TAP_MAP_SVH
`define DEBUG_TAP_MAP_SVH

`define TAP_IR_W         5
`define TAP_ID_W         32
`define TAP_CHAIN_W      5

`define INSTR_CHAIN_WR   5'h00
`define INSTR_SCAN_SEL   5'h02
`define INSTR_RESTART    5'h04
`define INSTR_HALT       5'h08
`define INSTR_CHAIN_RD   5'h0C
`define INSTR_ITR_SEL    5'h1D
`define INSTR_IDENT      5'h1E
`define INSTR_BYPASS     5'h1F

`define IR_CAPTURE_VAL   5'h01
`define CHAIN_SELECT_REG_CAPTURE    5'h10
`define CHAIN_SELECT_REG_RESET      5'h03
`define CHAIN_SELECT_REG_ITR_CHAIN  5'h04

`define BYPASS_CAPTURE   1'h0

// part number value is arbitrary
`define ID_PART_NUMBER   16'h5A3C
`define ID_VERSION_W     4
`define ID_MANUF_W       11
`define ID_FIXED_LSB     1'h1

`endif

// file: shared/debug_tap_pkg.sv
// types shared by the debug tap controller
package debug_tap_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        PATH_CHAIN,
        PATH_CHAIN_SELECT_REG,
        PATH_IDENT,
        PATH_BYPASS
    } dr_path_t;

endpackage : debug_tap_pkg

// file: src/debug_tap_instruction_decode.sv
// debug test access port: tap state machine, instruction decode, bypass, id, chain select
`timescale 1ns/1ps
`default_nettype none
`include "debug_tap_map.svh"

// Summary of operation
// - five-bit instruction and chain select registers
// - code 00000 selects chain, writing it
// - code 00010 places chain select register
// - restart code resumes core at Run-Test/Idle
// - halt code stops core if halt enabled
// - code 01100 selects chain for reading
// - code 11101 means write, chain four
// - code 11110 connects 32-bit identification register
// - code 11111 bypass, first bit zero
// - every unused code decodes as bypass
// - identification captured, shifted lsb first
// - version, manufacturer from pins; part fixed
// - Capture-IR loads 00001, shifts lsb first
// - Update-IR makes shifted code current
// - tap reset makes identification current
// - chain select captures 10000, resets three
// - read never updates chain; write does
module debug_tap_instruction_decode (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      debug_serial_in,
    output logic                           debug_serial_out,
    output logic                           debug_serial_out_en,
    input  wire logic [`ID_VERSION_W-1:0]  id_version,
    input  wire logic [`ID_MANUF_W-1:0]    id_manufacturer,
    input  wire logic                      halt_mode_en,
    output logic                           halt_req,
    output logic                           restart_req,
    output logic [`TAP_CHAIN_W-1:0]        chain_select,
    output logic                           chain_capture,
    output logic                           chain_shift,
    output logic                           chain_update,
    output logic                           chain_read,
    input  wire logic                      chain_serial_out
);

    // ---------------- decode ----------------
    function automatic debug_tap_pkg::dr_path_t path_of(input logic [`TAP_IR_W-1:0] code);
        unique case (code)
            `INSTR_CHAIN_WR: path_of = debug_tap_pkg::PATH_CHAIN;
            `INSTR_CHAIN_RD: path_of = debug_tap_pkg::PATH_CHAIN;
            `INSTR_SCAN_SEL: path_of = debug_tap_pkg::PATH_CHAIN_SELECT_REG;
            `INSTR_IDENT:    path_of = debug_tap_pkg::PATH_IDENT;
            default:         path_of = debug_tap_pkg::PATH_BYPASS;
        endcase
    endfunction : path_of

    // the instruction-transfer shortcut is acted on in two registers at Update-IR
    function automatic logic is_itr_sel(input logic [`TAP_IR_W-1:0] code);
        is_itr_sel = (code == `INSTR_ITR_SEL);
    endfunction : is_itr_sel

    debug_tap_pkg::tap_state_t  state_q;
    debug_tap_pkg::tap_state_t  state_d;
    debug_tap_pkg::dr_path_t    path;

    logic [`TAP_IR_W-1:0]     ir_shift_q;
    logic [`TAP_IR_W-1:0]     tap_instruction_q;
    logic [`TAP_CHAIN_W-1:0]  chain_select_reg_shift_q;
    logic [`TAP_CHAIN_W-1:0]  chain_select_reg_q;
    logic                     bypass_bit_q;
    logic [`TAP_ID_W-1:0]     id_shift_q;
    logic [`ID_VERSION_W-1:0] ver_meta_q;
    logic [`ID_VERSION_W-1:0] ver_q;
    logic [`ID_MANUF_W-1:0]   man_meta_q;
    logic [`ID_MANUF_W-1:0]   man_q;
    logic                     halt_tgl_q;
    logic                     restart_tgl_q;
    logic                     serial_out_d;

    assign path = path_of(tap_instruction_q);

    // tap state qualifiers, each decoded once and shared by the sections below
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic enter_idle;

    assign capture_ir = (state_q == debug_tap_pkg::CAPTURE_IR);
    assign shift_ir   = (state_q == debug_tap_pkg::SHIFT_IR);
    assign update_ir  = (state_q == debug_tap_pkg::UPDATE_IR);
    assign capture_dr = (state_q == debug_tap_pkg::CAPTURE_DR);
    assign shift_dr   = (state_q == debug_tap_pkg::SHIFT_DR);
    assign update_dr  = (state_q == debug_tap_pkg::UPDATE_DR);
    assign enter_idle = (state_q != debug_tap_pkg::RUN_TEST_IDLE)
                        && (state_d == debug_tap_pkg::RUN_TEST_IDLE);

    // ---------------- tap state machine (tck) ----------------
    always_comb begin
        unique case (state_q)
            debug_tap_pkg::TEST_LOGIC_RESET:
                state_d = tms ? debug_tap_pkg::TEST_LOGIC_RESET : debug_tap_pkg::RUN_TEST_IDLE;
            debug_tap_pkg::RUN_TEST_IDLE:
                state_d = tms ? debug_tap_pkg::SELECT_DR : debug_tap_pkg::RUN_TEST_IDLE;
            debug_tap_pkg::SELECT_DR:
                state_d = tms ? debug_tap_pkg::SELECT_IR : debug_tap_pkg::CAPTURE_DR;
            debug_tap_pkg::CAPTURE_DR:
                state_d = tms ? debug_tap_pkg::EXIT1_DR : debug_tap_pkg::SHIFT_DR;
            debug_tap_pkg::SHIFT_DR:
                state_d = tms ? debug_tap_pkg::EXIT1_DR : debug_tap_pkg::SHIFT_DR;
            debug_tap_pkg::EXIT1_DR:
                state_d = tms ? debug_tap_pkg::UPDATE_DR : debug_tap_pkg::PAUSE_DR;
            debug_tap_pkg::PAUSE_DR:
                state_d = tms ? debug_tap_pkg::EXIT2_DR : debug_tap_pkg::PAUSE_DR;
            debug_tap_pkg::EXIT2_DR:
                state_d = tms ? debug_tap_pkg::UPDATE_DR : debug_tap_pkg::SHIFT_DR;
            debug_tap_pkg::UPDATE_DR:
                state_d = tms ? debug_tap_pkg::SELECT_DR : debug_tap_pkg::RUN_TEST_IDLE;
            debug_tap_pkg::SELECT_IR:
                state_d = tms ? debug_tap_pkg::TEST_LOGIC_RESET : debug_tap_pkg::CAPTURE_IR;
            debug_tap_pkg::CAPTURE_IR:
                state_d = tms ? debug_tap_pkg::EXIT1_IR : debug_tap_pkg::SHIFT_IR;
            debug_tap_pkg::SHIFT_IR:
                state_d = tms ? debug_tap_pkg::EXIT1_IR : debug_tap_pkg::SHIFT_IR;
            debug_tap_pkg::EXIT1_IR:
                state_d = tms ? debug_tap_pkg::UPDATE_IR : debug_tap_pkg::PAUSE_IR;
            debug_tap_pkg::PAUSE_IR:
                state_d = tms ? debug_tap_pkg::EXIT2_IR : debug_tap_pkg::PAUSE_IR;
            debug_tap_pkg::EXIT2_IR:
                state_d = tms ? debug_tap_pkg::UPDATE_IR : debug_tap_pkg::SHIFT_IR;
            debug_tap_pkg::UPDATE_IR:
                state_d = tms ? debug_tap_pkg::SELECT_DR : debug_tap_pkg::RUN_TEST_IDLE;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            state_q <= debug_tap_pkg::TEST_LOGIC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // strap pins are static but still cross into the test clock domain
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ver_meta_q <= '0;
            ver_q      <= '0;
            man_meta_q <= '0;
            man_q      <= '0;
        end else begin
            ver_meta_q <= id_version;
            ver_q      <= ver_meta_q;
            man_meta_q <= id_manufacturer;
            man_q      <= man_meta_q;
        end
    end

    // ---------------- instruction register ----------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ir_shift_q <= `IR_CAPTURE_VAL;
        end else if (capture_ir) begin
            ir_shift_q <= `IR_CAPTURE_VAL;
        end else if (shift_ir) begin
            ir_shift_q <= {debug_serial_in, ir_shift_q[`TAP_IR_W-1:1]};
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            tap_instruction_q <= `INSTR_IDENT;
        end else if (state_q == debug_tap_pkg::TEST_LOGIC_RESET) begin
            tap_instruction_q <= `INSTR_IDENT;
        end else if (update_ir) begin
            if (is_itr_sel(ir_shift_q)) begin
                // once in force it is indistinguishable from a write with chain four
                tap_instruction_q <= `INSTR_CHAIN_WR;
            end else begin
                tap_instruction_q <= ir_shift_q;
            end
        end
    end

    // ---------------- chain select register ----------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            chain_select_reg_shift_q <= `CHAIN_SELECT_REG_CAPTURE;
        end else if (path == debug_tap_pkg::PATH_CHAIN_SELECT_REG) begin
            if (capture_dr) begin
                chain_select_reg_shift_q <= `CHAIN_SELECT_REG_CAPTURE;
            end else if (shift_dr) begin
                chain_select_reg_shift_q <= {debug_serial_in, chain_select_reg_shift_q[`TAP_CHAIN_W-1:1]};
            end
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            chain_select_reg_q <= `CHAIN_SELECT_REG_RESET;
        end else if (state_q == debug_tap_pkg::TEST_LOGIC_RESET) begin
            chain_select_reg_q <= `CHAIN_SELECT_REG_RESET;
        end else if (update_ir && is_itr_sel(ir_shift_q)) begin
            chain_select_reg_q <= `CHAIN_SELECT_REG_ITR_CHAIN;
        end else if (update_dr && path == debug_tap_pkg::PATH_CHAIN_SELECT_REG) begin
            chain_select_reg_q <= chain_select_reg_shift_q;
        end
    end

    // ---------------- bypass and identification ----------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            bypass_bit_q <= `BYPASS_CAPTURE;
        end else if (path == debug_tap_pkg::PATH_BYPASS) begin
            if (capture_dr) begin
                bypass_bit_q <= `BYPASS_CAPTURE;
            end else if (shift_dr) begin
                bypass_bit_q <= debug_serial_in;
            end
        end
    end

    // shifted-in bits are dropped: nothing is loaded back at Update-DR
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            id_shift_q <= '0;
        end else if (path == debug_tap_pkg::PATH_IDENT) begin
            if (capture_dr) begin
                id_shift_q <= {ver_q, `ID_PART_NUMBER, man_q, `ID_FIXED_LSB};
            end else if (shift_dr) begin
                id_shift_q <= {debug_serial_in, id_shift_q[`TAP_ID_W-1:1]};
            end
        end
    end

    // ---------------- serial out, changes on falling test clock ----------------
    always_comb begin
        serial_out_d = bypass_bit_q;
        if (shift_ir) begin
            serial_out_d = ir_shift_q[0];
        end else begin
            unique case (path)
                debug_tap_pkg::PATH_CHAIN:  serial_out_d = chain_serial_out;
                debug_tap_pkg::PATH_CHAIN_SELECT_REG:  serial_out_d = chain_select_reg_shift_q[0];
                debug_tap_pkg::PATH_IDENT:  serial_out_d = id_shift_q[0];
                debug_tap_pkg::PATH_BYPASS: serial_out_d = bypass_bit_q;
            endcase
        end
    end

    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            debug_serial_out    <= 1'h0;
            debug_serial_out_en <= 1'h0;
        end else begin
            debug_serial_out    <= serial_out_d;
            debug_serial_out_en <= shift_dr || shift_ir;
        end
    end

    // ---------------- scan chain strobes (tck) ----------------
    // strobes are flops fed from the next state so they coincide with the tap state
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            chain_capture <= 1'h0;
            chain_shift   <= 1'h0;
            chain_update  <= 1'h0;
        end else begin
            chain_capture <= (path == debug_tap_pkg::PATH_CHAIN)
                             && (state_d == debug_tap_pkg::CAPTURE_DR);
            chain_shift   <= (path == debug_tap_pkg::PATH_CHAIN)
                             && (state_d == debug_tap_pkg::SHIFT_DR);
            chain_update  <= (tap_instruction_q == `INSTR_CHAIN_WR)
                             && (state_d == debug_tap_pkg::UPDATE_DR);
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            chain_select <= `CHAIN_SELECT_REG_RESET;
            chain_read   <= 1'h0;
        end else begin
            chain_select <= chain_select_reg_q;
            chain_read   <= (tap_instruction_q == `INSTR_CHAIN_RD);
        end
    end

    // ---------------- halt and restart requests ----------------
    // both take effect as the tap enters Run-Test/Idle so several cores can act together
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            halt_tgl_q <= 1'h0;
        end else if (enter_idle && tap_instruction_q == `INSTR_HALT) begin
            halt_tgl_q <= ~halt_tgl_q;
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            restart_tgl_q <= 1'h0;
        end else if (enter_idle && tap_instruction_q == `INSTR_RESTART) begin
            restart_tgl_q <= ~restart_tgl_q;
        end
    end

    // a toggle rather than a level, so no request is lost to the clock ratio
    logic [2:0] halt_sync_q;
    logic [2:0] restart_sync_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_sync_q <= '0;
        end else begin
            halt_sync_q <= {halt_sync_q[1:0], halt_tgl_q};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restart_sync_q <= '0;
        end else begin
            restart_sync_q <= {restart_sync_q[1:0], restart_tgl_q};
        end
    end

    // a halt with halt mode off is simply dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_req <= 1'h0;
        end else begin
            halt_req <= (halt_sync_q[2] ^ halt_sync_q[1]) && halt_mode_en;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restart_req <= 1'h0;
        end else begin
            restart_req <= restart_sync_q[2] ^ restart_sync_q[1];
        end
    end

endmodule : debug_tap_instruction_decode

`default_nettype wire

// file: tb/tap_probe.sv
// behavioural debug probe driving the test port
`timescale 1ns/1ps
`default_nettype none
module tap_probe (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    // tck stands low between steps; serial out is read before the rise
    task automatic step(input logic m, input logic d, output logic q);
        #1 q = tdo;
        tms = m;
        tdi = d;
        #5 tck = 1'h1;
        #6 tck = 1'h0;
    endtask : step
    // from Run-Test/Idle through one leg, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [39:0] din,
                        output logic [39:0] dout);
        logic q;
        dout = '0;
        step(1'h1, ~tdi, q);
        if (ir) step(1'h1, ~tdi, q);
        step(1'h0, ~tdi, q);
        step(1'h0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'h1, ~tdi, q);
        step(1'h0, ~tdi, q);
    endtask : scan
    task automatic tap_reset;
        logic q;
        repeat (5) step(1'h1, ~tdi, q);
        step(1'h0, ~tdi, q);
    endtask : tap_reset
endmodule : tap_probe
`default_nettype wire

// file: tb/debug_tap_properties.sv
// port assertions for the debug tap controller
`timescale 1ns/1ps
`default_nettype none
`include "debug_tap_map.svh"
module debug_tap_props (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   tck,
    input wire logic                   halt_mode_en,
    input wire logic                   halt_req,
    input wire logic                   restart_req,
    input wire logic [`TAP_CHAIN_W-1:0] chain_select,
    input wire logic                   chain_capture,
    input wire logic                   chain_shift,
    input wire logic                   chain_update,
    input wire logic                   chain_read,
    input wire logic                   debug_serial_out_en
);
    cap_once_a: assert property (@(posedge tck) disable iff (rst)
        chain_capture |=> !chain_capture) else $error("capture held");
    cap_then_a: assert property (@(posedge tck) disable iff (rst)
        chain_capture |=> !chain_update) else $error("update after capture");
    upd_once_a: assert property (@(posedge tck) disable iff (rst)
        chain_update |=> !chain_update) else $error("update held");
    write_only_a: assert property (@(posedge tck) disable iff (rst)
        chain_update |-> !chain_read) else $error("update while reading");
    shift_drive_a: assert property (@(posedge tck) disable iff (rst)
        chain_shift |-> debug_serial_out_en) else $error("shift undriven");
    halt_gate_a: assert property (@(posedge clk) disable iff (rst)
        halt_req |-> $past(halt_mode_en)) else $error("halt while disabled");
    halt_pulse_a: assert property (@(posedge clk) disable iff (rst)
        halt_req |=> !halt_req) else $error("halt pulse long");
    restart_pulse_a: assert property (@(posedge clk) disable iff (rst)
        restart_req |=> !restart_req) else $error("restart pulse long");
    reset_chain_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> chain_select == `CHAIN_SELECT_REG_RESET) else $error("reset chain");
    cover property (@(posedge tck) chain_update);
    cover property (@(posedge clk) halt_req);
    cover property (@(posedge clk) restart_req);
endmodule : debug_tap_props
bind debug_tap_instruction_decode debug_tap_props u_props (
    .clk(clk), .rst(rst), .tck(tck), .halt_mode_en(halt_mode_en),
    .halt_req(halt_req), .restart_req(restart_req), .chain_select(chain_select),
    .chain_capture(chain_capture), .chain_shift(chain_shift),
    .chain_update(chain_update), .chain_read(chain_read),
    .debug_serial_out_en(debug_serial_out_en));
`default_nettype wire

// file: tb/tb_debug_tap_instruction_decode.sv
// self-checking bench for the debug tap controller
`timescale 1ns/1ps
`default_nettype none
`include "debug_tap_map.svh"
module tb_debug_tap_instruction_decode;
    logic        clk, rst, tck, tms, debug_serial_in, debug_serial_out;
    logic        debug_serial_out_en, halt_mode_en, halt_req, restart_req;
    logic        chain_capture, chain_shift, chain_update, chain_read;
    logic        chain_serial_out;
    logic [3:0]  id_version;
    logic [10:0] id_manufacturer;
    logic [4:0]  chain_select;
    logic [15:0] rnd;
    logic [39:0] d, q;
    int          n_mismatch, checked, n_halt, n_restart, n_update;

    debug_tap_instruction_decode dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .debug_serial_in(debug_serial_in),
        .debug_serial_out(debug_serial_out), .debug_serial_out_en(debug_serial_out_en),
        .id_version(id_version), .id_manufacturer(id_manufacturer),
        .halt_mode_en(halt_mode_en), .halt_req(halt_req), .restart_req(restart_req),
        .chain_select(chain_select), .chain_capture(chain_capture),
        .chain_shift(chain_shift), .chain_update(chain_update),
        .chain_read(chain_read), .chain_serial_out(chain_serial_out));
    tap_probe p (.tck(tck), .tms(tms), .tdi(debug_serial_in), .tdo(debug_serial_out));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (halt_req === 1'h1) n_halt++;
        if (restart_req === 1'h1) n_restart++;
    end
    always @(posedge tck) begin
        if (chain_update === 1'h1) n_update++;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // chain paths have unknown length, so only the routed bit is expected
    function automatic logic [39:0] exp_dr(input logic [4:0] c, input logic [39:0] x);
        logic [31:0] id;
        id = {id_version, `ID_PART_NUMBER, id_manufacturer, `ID_FIXED_LSB};
        case (c)
            `INSTR_IDENT:    return {x[7:0], id};
            `INSTR_SCAN_SEL: return {x[34:0], `CHAIN_SELECT_REG_CAPTURE};
            `INSTR_CHAIN_WR, `INSTR_CHAIN_RD, `INSTR_ITR_SEL: return {40{chain_serial_out}};
            default:         return {x[38:0], `BYPASS_CAPTURE};
        endcase
    endfunction : exp_dr

    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // straps and chain data change only while tck stands still
    task automatic drive(input logic h);
        @(negedge clk);
        rnd = lfsr(rnd);
        id_version = rnd[3:0];
        id_manufacturer = rnd[14:4];
        chain_serial_out = rnd[15];
        halt_mode_en = h;
        d = {rnd[7:0], rnd, ~rnd};
    endtask : drive
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic id_check;
        drive(1'h0);
        // leaves Test-Logic-Reset after a reset, merely idles otherwise
        p.step(1'h0, 1'h0, q[0]);
        p.scan(1'h0, 40, d, q);
        cmp(q, exp_dr(`INSTR_IDENT, d));
        cmp(40'(chain_select), 40'(`CHAIN_SELECT_REG_RESET));
    endtask : id_check

    initial begin
        rst = 1'h1;
        rnd = 16'h08F4;
        {halt_mode_en, chain_serial_out, id_version, id_manufacturer} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        id_check();
        for (int c = 0; c < 32; c++) begin
            drive(1'h0);
            p.scan(1'h1, 5, 40'(c), q);
            cmp(q, 40'(`IR_CAPTURE_VAL));
            p.scan(1'h0, 40, d, q);
            cmp(q, exp_dr(5'(c), d));
            // the chain number output follows its register one tck later
            p.step(1'h0, 1'h0, q[0]);
            if (c == `INSTR_SCAN_SEL) cmp(40'(chain_select), 40'(d[39:35]));
            if (c == `INSTR_ITR_SEL) cmp(40'(chain_select), 40'(`CHAIN_SELECT_REG_ITR_CHAIN));
            if (c == `INSTR_CHAIN_RD) cmp(40'(chain_read), 40'h1);
        end
        repeat (10) @(posedge clk);
        cmp(40'(n_restart), 40'h2);
        cmp(40'(n_halt), 40'h0);
        cmp(40'(n_update), 40'h2);
        drive(1'h1);
        p.scan(1'h1, 5, 40'(`INSTR_HALT), q);
        // a halt is issued only on entry to Run-Test/Idle, so pass through a short leg
        p.scan(1'h0, 1, d, q);
        cmp(q, 40'h0);
        repeat (10) @(posedge clk);
        cmp(40'(n_halt), 40'h1);
        p.scan(1'h1, 5, 40'(`INSTR_SCAN_SEL), q);
        p.tap_reset();
        id_check();
        p.scan(1'h1, 5, 40'(`INSTR_BYPASS), q);
        @(negedge clk) rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        id_check();
        end_of_test();
    end
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_debug_tap_instruction_decode
`default_nettype wire
